// >>> mic_cfg.svh
`ifndef MIC_CFG_SVH
`define MIC_CFG_SVH

// ==========================================================
// register byte offsets on the apb bus
`define MIC_OFF_EDGE  8'h00
`define MIC_OFF_CTRL0 8'h04
`define MIC_OFF_CTRL1 8'h08
`define MIC_OFF_CTRL2 8'h0C
`define MIC_OFF_TMR0  8'h10
`define MIC_OFF_TMR1  8'h14
`define MIC_OFF_EELV  8'h18
`define MIC_OFF_STAT  8'h1C

// ==========================================================
// field positions and reset values
`define MIC_GIE_BIT   0
`define MIC_RISE_BIT  0
`define MIC_FALL_BIT  1
`define MIC_RST_BYTE  8'h00
`define MIC_RST_NIB   4'h0

// ==========================================================
// source counts and vector placement
`define MIC_NMAIN     8
`define MIC_NSUB      6
`define MIC_NGRP      3
`define MIC_PC_W      12
`define MIC_VEC_BASE  12'h004
`define MIC_VEC_STEP  12'h004

`endif

// >>> mic_pkg.sv
package mic_pkg;

   // ==========================================================
   // service sequencer states
   typedef enum logic [2:0] {
      st_idle = 3'b001,
      st_push = 3'b010,
      st_load = 3'b100
   } mic_state_t;

   typedef logic [2:0] mic_idx_t;

endpackage

// >>> mic_top.sv
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ns
`include "mic_cfg.svh"
module mic_top
   import mic_pkg::*;
(
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic                 ext_irq_pin_a,
   input  wire logic                 ext_irq_pin_b,
   input  wire logic                 ov_event,
   input  wire logic                 oc_event,
   input  wire logic                 adc_done_event,
   input  wire logic                 tmr0_cmp_p_event,
   input  wire logic                 tmr0_cmp_a_event,
   input  wire logic                 tmr1_cmp_p_event,
   input  wire logic                 tmr1_cmp_a_event,
   input  wire logic                 low_volt_event,
   input  wire logic                 eeprom_done_event,
   input  wire logic                 stack_full,
   input  wire logic                 core_accept,
   input  wire logic                 ret_done,
   input  wire logic                 sleep_mode,
   input  wire logic [1:0]           pullup_sel,
   output logic                      stack_push,
   output logic                      pc_load,
   output logic      [`MIC_PC_W-1:0] vector_addr,
   output logic                      wake_up,
   output logic      [1:0]           pullup_en
);

   // ==========================================================
   // state
   mic_state_t              state_reg;
   mic_state_t              state_next;
   logic [`MIC_NMAIN-1:0]   main_flag_reg;
   logic [`MIC_NMAIN-1:0]   main_en_reg;
   logic [`MIC_NSUB-1:0]    sub_flag_reg;
   logic [`MIC_NSUB-1:0]    sub_en_reg;
   logic [3:0]              edge_sel_reg;
   logic                    gie_reg;
   logic                    gie_next;
   mic_idx_t                sel_reg;
   mic_idx_t                sel_idx;
   logic [1:0]              pin_s1_reg;
   logic [1:0]              pin_s2_reg;
   logic [1:0]              pin_s3_reg;
   logic [1:0]              pin_lvl_reg;

   wire  [1:0]              pin_raw;
   wire  [1:0]              pin_edge;
   wire  [1:0]              pin_en;
   wire  [`MIC_NMAIN-1:0]   main_set;
   wire  [`MIC_NMAIN-1:0]   main_wm;
   wire  [`MIC_NMAIN-1:0]   main_fwd;
   wire  [`MIC_NMAIN-1:0]   main_ewd;
   wire  [`MIC_NMAIN-1:0]   main_svc;
   wire  [`MIC_NMAIN-1:0]   main_req;
   wire  [`MIC_NSUB-1:0]    sub_evt;
   wire  [`MIC_NSUB-1:0]    sub_wm;
   wire  [`MIC_NSUB-1:0]    sub_fwd;
   wire  [`MIC_NSUB-1:0]    sub_ewd;
   wire  [`MIC_NGRP-1:0]    grp_ok;
   wire  [`MIC_NGRP-1:0]    grp_set;
   wire                     any_req;
   wire                     take;
   wire                     flag_rise;

   // ==========================================================
   // apb decode
   wire       acc      = psel & penable & pready;
   wire       wr       = acc & pwrite;
   wire       hit_edge = paddr == `MIC_OFF_EDGE;
   wire       hit_c0   = paddr == `MIC_OFF_CTRL0;
   wire       hit_c1   = paddr == `MIC_OFF_CTRL1;
   wire       hit_c2   = paddr == `MIC_OFF_CTRL2;
   wire       hit_t0   = paddr == `MIC_OFF_TMR0;
   wire       hit_t1   = paddr == `MIC_OFF_TMR1;
   wire       hit_el   = paddr == `MIC_OFF_EELV;
   wire       hit_st   = paddr == `MIC_OFF_STAT;
   wire       hit_any  = hit_edge | hit_c0 | hit_c1 | hit_c2 |
                         hit_t0 | hit_t1 | hit_el | hit_st;
   wire       wr_edge  = wr & hit_edge;
   wire       wr_c0    = wr & hit_c0;
   wire       wr_c1    = wr & hit_c1;
   wire       wr_c2    = wr & hit_c2;
   wire       wr_t0    = wr & hit_t0;
   wire       wr_t1    = wr & hit_t1;
   wire       wr_el    = wr & hit_el;
   wire       setup    = psel & ~penable;
   wire [7:0] rd_c0;
   wire [7:0] rd_c1;
   wire [7:0] rd_c2;
   wire [7:0] rd_t0;
   wire [7:0] rd_t1;
   wire [7:0] rd_el;
   wire [7:0] rd_st;
   wire [7:0] rd_mux;

   // read views; unimplemented bits are zero
   assign rd_c0 = {1'b0, main_flag_reg[0], main_flag_reg[2],
                   main_flag_reg[1], main_en_reg[0], main_en_reg[2],
                   main_en_reg[1], gie_reg};
   assign rd_c1 = {main_flag_reg[7], main_flag_reg[6:4],
                   main_en_reg[7], main_en_reg[6:4]};
   assign rd_c2 = {1'b0, main_flag_reg[3], 3'h0,
                   main_en_reg[3], 2'h0};
   assign rd_t0 = {2'h0, sub_flag_reg[1:0], 2'h0, sub_en_reg[1:0]};
   assign rd_t1 = {2'h0, sub_flag_reg[3:2], 2'h0,
                   sub_en_reg[3:2]};
   assign rd_el = {2'h0, sub_flag_reg[5:4], 2'h0,
                   sub_en_reg[5:4]};
   assign rd_st = {3'h0, ~state_reg[0], any_req, sel_idx};
   assign rd_mux = hit_edge ? {4'h0, edge_sel_reg} :
                   hit_c0   ? rd_c0 :
                   hit_c1   ? rd_c1 :
                   hit_c2   ? rd_c2 :
                   hit_t0   ? rd_t0 :
                   hit_t1   ? rd_t1 :
                   hit_el   ? rd_el :
                   hit_st   ? rd_st : 8'h00;

   // answer in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~hit_any;
         prdata  <= setup ? {24'h00_0000, rd_mux} : 32'h0000_0000;
      end
   end

   // edge select register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         edge_sel_reg <= `MIC_RST_NIB;
      else if (wr_edge)
         edge_sel_reg <= pwdata[3:0];
   end

   // ==========================================================
   // external pins: three-stage sync, agreed-level edge detect
   assign pin_raw = {ext_irq_pin_b, ext_irq_pin_a};
   assign pin_en  = {main_en_reg[3], main_en_reg[0]};

   generate
      for (genvar p = 0; p < 2; p++) begin : g_pin
         wire rise = pin_s2_reg[p] & pin_s3_reg[p] & ~pin_lvl_reg[p];
         wire fall = ~pin_s2_reg[p] & ~pin_s3_reg[p] & pin_lvl_reg[p];
         // code bit 0 picks rising, bit 1 falling, 00 is off
         assign pin_edge[p] = pin_en[p] &
            ((rise & edge_sel_reg[2*p+`MIC_RISE_BIT]) |
             (fall & edge_sel_reg[2*p+`MIC_FALL_BIT]));
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pin_s1_reg[p]  <= 1'b0;
               pin_s2_reg[p]  <= 1'b0;
               pin_s3_reg[p]  <= 1'b0;
               pin_lvl_reg[p] <= 1'b0;
            end else begin
               pin_s1_reg[p]  <= pin_raw[p];
               pin_s2_reg[p]  <= pin_s1_reg[p];
               pin_s3_reg[p]  <= pin_s2_reg[p];
               if (pin_s2_reg[p] == pin_s3_reg[p])
                  pin_lvl_reg[p] <= pin_s3_reg[p];
            end
         end
      end
   endgenerate

   // pull-high choice passes through untouched by interrupt use
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         pullup_en <= 2'b00;
      else
         pullup_en <= pullup_sel;
   end

   // ==========================================================
   // grouped sources: timer 0, timer 1, eeprom/low-voltage
   assign sub_evt = {eeprom_done_event, low_volt_event,
                     tmr1_cmp_a_event, tmr1_cmp_p_event,
                     tmr0_cmp_a_event, tmr0_cmp_p_event};
   assign sub_wm  = {wr_el, wr_el, wr_t1, wr_t1, wr_t0, wr_t0};
   assign sub_fwd = {3{pwdata[5:4]}};
   assign sub_ewd = {3{pwdata[1:0]}};

   generate
      for (genvar s = 0; s < `MIC_NSUB; s++) begin : g_sub
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sub_flag_reg[s] <= 1'b0;
               sub_en_reg[s]   <= 1'b0;
            end else begin
               // set beats a clearing write; no auto clear
               sub_flag_reg[s] <= sub_evt[s] |
                  (sub_wm[s] ? sub_fwd[s] : sub_flag_reg[s]);
               if (sub_wm[s])
                  sub_en_reg[s] <= sub_ewd[s];
            end
         end
      end
      for (genvar g = 0; g < `MIC_NGRP; g++) begin : g_grp
         assign grp_set[g] = |sub_evt[2*g+1:2*g];
         assign grp_ok[g]  = |(sub_flag_reg[2*g+1:2*g] &
                               sub_en_reg[2*g+1:2*g]);
      end
   endgenerate

   // ==========================================================
   // primary flags, index order is vector order
   assign main_set = {adc_done_event, grp_set, pin_edge[1],
                      oc_event, ov_event, pin_edge[0]};
   assign main_wm  = {wr_c1, wr_c1, wr_c1, wr_c1, wr_c2,
                      wr_c0, wr_c0, wr_c0};
   assign main_fwd = {pwdata[7], pwdata[6:4], pwdata[6],
                      pwdata[5], pwdata[4], pwdata[6]};
   assign main_ewd = {pwdata[3], pwdata[2:0], pwdata[2],
                      pwdata[2], pwdata[1], pwdata[3]};
   assign main_req = main_flag_reg & main_en_reg &
                     {1'b1, grp_ok, 4'hF};

   generate
      for (genvar m = 0; m < `MIC_NMAIN; m++) begin : g_main
         assign main_svc[m] = take & (sel_idx == mic_idx_t'(m));
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               main_flag_reg[m] <= 1'b0;
               main_en_reg[m]   <= 1'b0;
            end else begin
               // a new event wins over service or write clear
               main_flag_reg[m] <= main_set[m] |
                  (main_wm[m] ? main_fwd[m] :
                   main_flag_reg[m] & ~main_svc[m]);
               if (main_wm[m])
                  main_en_reg[m] <= main_ewd[m];
            end
         end
      end
   endgenerate

   // ==========================================================
   // fixed priority, lowest index first
   always_comb begin
      sel_idx = 3'h0;
      for (int i = `MIC_NMAIN - 1; i >= 0; i--) begin
         if (main_req[i])
            sel_idx = mic_idx_t'(i);
      end
   end

   assign any_req = |main_req;
   assign take    = state_reg[0] & gie_reg & any_req &
                    ~stack_full & core_accept;

   // global enable: write, cleared on take, return restores
   always_comb begin
      gie_next = gie_reg;
      if (ret_done)
         gie_next = 1'b1;
      if (take)
         gie_next = 1'b0;
      if (wr_c0)
         gie_next = pwdata[`MIC_GIE_BIT];
   end

   // sequencer: push the return address, then load vector
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         st_idle: begin
            if (take)
               state_next = st_push;
         end
         st_push: state_next = st_load;
         st_load: state_next = st_idle;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= st_idle;
         gie_reg   <= 1'b0;
         sel_reg   <= 3'h0;
      end else begin
         state_reg <= state_next;
         gie_reg   <= gie_next;
         if (take)
            sel_reg <= sel_idx;
      end
   end

   // core strobes and vector
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stack_push  <= 1'b0;
         pc_load     <= 1'b0;
         vector_addr <= 12'h000;
      end else begin
         stack_push  <= take;
         pc_load     <= state_reg == st_push;
         if (state_reg == st_push)
            vector_addr <= `MIC_VEC_BASE +
                           12'(sel_reg) * `MIC_VEC_STEP;
      end
   end

   // ==========================================================
   // wake on a flag going low to high; enables ignored except pin enables, which gate the pin flags
   assign flag_rise = |(main_set & ~main_flag_reg) |
                      |(sub_evt & ~sub_flag_reg);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         wake_up <= 1'b0;
      else
         wake_up <= sleep_mode & flag_rise;
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   gie_gate_a: assert property (!gie_reg |-> !take)
      else $error("interrupt taken with global enable low");
   stack_gate_a: assert property (stack_full |-> !take)
      else $error("interrupt taken with stack full");
   gie_clear_a: assert property (
      take && !wr_c0 |=> !gie_reg)
      else $error("global enable not cleared on service");
   push_load_a: assert property (
      take |=> stack_push && !pc_load ##1 pc_load && !stack_push)
      else $error("push then load order broken");
   vector_val_a: assert property (
      take |-> ##2 vector_addr ==
         `MIC_VEC_BASE + 12'($past(sel_idx, 2)) * `MIC_VEC_STEP)
      else $error("wrong vector address");
   enable_need_a: assert property (
      take |-> main_en_reg[sel_idx] && main_flag_reg[sel_idx])
      else $error("disabled source vectored");
   svc_clear_a: assert property (
      take && !main_set[sel_idx] && !main_wm[sel_idx] |=>
         !main_flag_reg[sel_reg])
      else $error("serviced flag not cleared");
   ov_set_a: assert property (ov_event |=> main_flag_reg[1])
      else $error("over-voltage flag not set");
   sub_keep_a: assert property (
      take && !(|sub_wm) && !(|sub_evt) |=>
         $stable(sub_flag_reg))
      else $error("member flag changed by service");
   pri_low_a: assert property (
      take |-> (main_req & ~(8'hFF << sel_idx)) == 8'h00)
      else $error("priority order broken");
   rsvd_zero_a: assert property (
      pready && !pwrite && (hit_t1 || hit_el) |->
         prdata[7:6] == 2'h0 && prdata[3:2] == 2'h0)
      else $error("reserved bits read non-zero");
   wake_new_a: assert property (
      sleep_mode && !flag_rise |=> !wake_up)
      else $error("wake without a new flag");

   take_ext_c: cover property (take && sel_idx == 3'h0);
   take_grp_c: cover property (take && sel_idx == 3'h6);
   wake_c:     cover property (wake_up);
   stack_c:    cover property (stack_full && gie_reg && any_req);

endmodule

// >>> mic_core_model.sv
`timescale 1ns/1ns
// ==========================================================
// core stand-in: stack state, sleep state, return from service
module mic_core_model
   import mic_pkg::*;
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic stack_push,
   input  wire logic pc_load,
   input  wire logic hold_full,
   input  wire logic go_sleep,
   input  wire logic do_ret,
   input  wire logic stall,
   output logic      core_accept,
   output logic      stack_full,
   output logic      ret_done,
   output logic      sleep_mode,
   output logic      order_bad
);
   logic push_reg;

   // core state follows the bench one cycle late, like a real sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_accept <= 1'b0;
         stack_full  <= 1'b0;
         ret_done    <= 1'b0;
         sleep_mode  <= 1'b0;
         order_bad   <= 1'b0;
         push_reg    <= 1'b0;
      end else begin
         core_accept <= !stall || !core_accept; // slow core skips cycles
         stack_full  <= hold_full;
         ret_done    <= do_ret;
         sleep_mode  <= go_sleep;
         push_reg    <= stack_push;
         if (pc_load && !push_reg) begin
            order_bad <= 1'b1;
         end
      end
   end
endmodule

// >>> mcu_interrupt_controller_bench.sv
`timescale 1ns/1ns
`include "mic_cfg.svh"
// ==========================================================
// bench for the interrupt controller
module mcu_interrupt_controller_bench
   import mic_pkg::*;
;
   logic                 pclk, presetn, psel, penable, pwrite, pready;
   logic                 pslverr, ext_irq_pin_a, ext_irq_pin_b;
   logic [7:0]           paddr;
   logic [31:0]          pwdata, prdata;
   logic [8:0]           ev;
   logic [1:0]           pullup_sel, pullup_en;
   logic                 stack_full, core_accept, ret_done, sleep_mode;
   logic                 stack_push, pc_load, wake_up, order_bad;
   logic                 hold_full, go_sleep, do_ret, stall;
   logic [`MIC_PC_W-1:0] vector_addr;
   logic [55:0]          svc_tab [9];
   logic [23:0]          reg_tab [8];
   int                   err_total, n_tests, np, nw;

   // clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   mic_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .ext_irq_pin_a, .ext_irq_pin_b,
      .ov_event(ev[0]), .oc_event(ev[1]), .adc_done_event(ev[2]),
      .tmr0_cmp_p_event(ev[3]), .tmr0_cmp_a_event(ev[4]),
      .tmr1_cmp_p_event(ev[5]), .tmr1_cmp_a_event(ev[6]),
      .low_volt_event(ev[7]), .eeprom_done_event(ev[8]), .stack_full,
      .core_accept, .ret_done, .sleep_mode, .pullup_sel, .stack_push,
      .pc_load, .vector_addr, .wake_up, .pullup_en);

   mic_core_model core (.pclk, .presetn, .stack_push, .pc_load, .hold_full,
      .go_sleep, .do_ret, .stall, .core_accept, .stack_full, .ret_done,
      .sleep_mode, .order_bad);

   // ==========================================================
   // checking and closing
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task conclude;
      $display("checks %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // ==========================================================
   // apb master: setup, access until pready sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
      int i;
      i = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (i >= 20) begin
         chk("pready", 32'h00000001, 32'h00000000);
         conclude;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, {24'h000000, d}, r, e);
   endtask

   task rd(input logic [7:0] a, input logic [7:0] x, input logic xe);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h00000000, r, e);
      chk("prdata", {24'h000000, x}, r);
      chk("pslverr", {31'h00000000, xe}, {31'h00000000, e});
   endtask

   // ==========================================================
   // stimulus helpers
   task pulse(input int i);
      @(posedge pclk);
      ev[i] <= 1'b1;
      @(posedge pclk);
      ev[i] <= 1'b0;
   endtask

   task end_svc;
      @(posedge pclk);
      do_ret <= 1'b1;
      @(posedge pclk);
      do_ret <= 1'b0;
   endtask

   task pin(input int p, input logic l);
      @(posedge pclk);
      if (p == 1) ext_irq_pin_b <= l;
      else ext_irq_pin_a <= l;
      repeat (8) @(posedge pclk);
   endtask

   // counts push and wake strobes over n edges
   task watch(input int n);
      np = 0;
      nw = 0;
      repeat (n) begin
         @(posedge pclk);
         np += (stack_push === 1'b1);
         nw += (wake_up === 1'b1);
      end
   endtask

   task vec(input logic [11:0] x);
      int i;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pc_load !== 1'b1 && i < 40);
      if (i >= 40) begin
         chk("pc_load", 32'h00000001, 32'h00000000);
         conclude;
      end
      chk("vector_addr", {20'h00000, x}, {20'h00000, vector_addr});
   endtask

   // ==========================================================
   // main sequence
   initial begin
      logic [7:0]  c0, c1, ra, rv, x, ea, en;
      logic [3:0]  e;
      logic [11:0] v;
      logic [1:0]  cd;
      {psel, penable, pwrite, presetn} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      ev = 9'h000;
      {ext_irq_pin_a, ext_irq_pin_b, hold_full, go_sleep} = 4'h0;
      {do_ret, stall} = 2'b00;
      pullup_sel = 2'b00;
      err_total = 0;
      n_tests = 0;
      reg_tab = '{24'h00FF0F, 24'h047E7E, 24'h08FFFF, 24'h0CFF44,
                  24'h10FF33, 24'h14FF33, 24'h18FF33, 24'h20FF00};
      svc_tab = '{56'h02001000000800, 56'h04001000100C00,
                  56'h00081000202000, 56'h00011001301411,
                  56'h00011002401422, 56'h00021401501811,
                  56'h00021402601822, 56'h00041801701C11,
                  56'h00041802801C22};
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         ra = reg_tab[i][23:16];
         rd(ra, 8'h00, ra == 8'h20);
         wr(ra, reg_tab[i][15:8]);
         rd(ra, reg_tab[i][7:0], ra == 8'h20);
         wr(ra, 8'h00);
      end
      // one serviced source per row: vector, auto clears, member flags kept
      for (int i = 0; i < 9; i++) begin
         {c0, c1, ra, rv, e, v, x} = svc_tab[i];
         wr(`MIC_OFF_CTRL1, c1);
         wr(ra, rv);
         wr(`MIC_OFF_CTRL0, c0 | 8'h01);
         pulse(e);
         vec(v);
         rd(`MIC_OFF_CTRL0, c0, 1'b0);
         rd(`MIC_OFF_CTRL1, c1, 1'b0);
         rd(ra, x, 1'b0);
         wr(ra, 8'h00);
         wr(`MIC_OFF_CTRL1, 8'h00);
      end
      // flag kept but no vector while its enable or global enable is off
      wr(`MIC_OFF_CTRL0, 8'h01);
      pulse(0);
      watch(10);
      chk("stack_push", 0, np);
      rd(`MIC_OFF_CTRL0, 8'h11, 1'b0);
      wr(`MIC_OFF_CTRL0, 8'h12);
      watch(10);
      chk("stack_push", 0, np);
      wr(`MIC_OFF_CTRL0, 8'h13);
      vec(12'h008);
      rd(`MIC_OFF_CTRL0, 8'h02, 1'b0);
      pulse(1);
      rd(`MIC_OFF_CTRL0, 8'h22, 1'b0);
      // two pending, slow core: lowest index first, next after return
      stall <= 1'b1;
      wr(`MIC_OFF_CTRL0, 8'h36);
      end_svc;
      vec(12'h008);
      rd(`MIC_OFF_CTRL0, 8'h26, 1'b0);
      end_svc;
      vec(12'h00C);
      rd(`MIC_OFF_CTRL0, 8'h06, 1'b0);
      stall <= 1'b0;
      // full stack holds off acknowledgement
      hold_full <= 1'b1;
      wr(`MIC_OFF_CTRL0, 8'h03);
      pulse(0);
      watch(12);
      chk("stack_push", 0, np);
      hold_full <= 1'b0;
      vec(12'h008);
      wr(`MIC_OFF_CTRL0, 8'h00);
      // wake only on a new flag rise, enables off
      go_sleep <= 1'b1;
      watch(3);
      pulse(2);
      watch(4);
      chk("wake_up", 1, nw);
      pulse(2);
      watch(4);
      chk("wake_up", 0, nw);
      go_sleep <= 1'b0;
      wr(`MIC_OFF_CTRL1, 8'h00);
      // every edge code on both pins, last pass with pin enable off
      pullup_sel <= 2'b10;
      for (int p = 0; p < 2; p++) begin
         for (int k = 0; k < 5; k++) begin
            cd = (k == 4) ? 2'b11 : k[1:0];
            ea = (p == 1) ? `MIC_OFF_CTRL2 : `MIC_OFF_CTRL0;
            en = (k == 4) ? 8'h00 : ((p == 1) ? 8'h04 : 8'h08);
            wr(`MIC_OFF_EDGE, (p == 1) ? {4'h0, cd, 2'b00} : {6'h00, cd});
            wr(ea, en);
            pin(p, 1'b1);
            x = (en != 0 && cd[0]) ? (en | 8'h40) : en;
            rd(ea, x, 1'b0);
            wr(ea, en);
            pin(p, 1'b0);
            x = (en != 0 && cd[1]) ? (en | 8'h40) : en;
            rd(ea, x, 1'b0);
            wr(ea, 8'h00);
         end
      end
      chk("pullup_en", 32'h00000002, {30'h00000000, pullup_en});
      // pin services: vector, pin flag and global enable cleared
      wr(`MIC_OFF_EDGE, 8'h01);
      wr(`MIC_OFF_CTRL0, 8'h09);
      ext_irq_pin_a <= 1'b1;
      vec(12'h004);
      rd(`MIC_OFF_CTRL0, 8'h08, 1'b0);
      wr(`MIC_OFF_EDGE, 8'h04);
      wr(`MIC_OFF_CTRL2, 8'h04);
      wr(`MIC_OFF_CTRL0, 8'h01);
      ext_irq_pin_b <= 1'b1;
      vec(12'h010);
      rd(`MIC_OFF_CTRL2, 8'h04, 1'b0);
      rd(`MIC_OFF_CTRL0, 8'h00, 1'b0);
      chk("order_bad", 0, {31'h00000000, order_bad});
      // mid-run reset clears registers, vector address and pull-up enables
      wr(`MIC_OFF_CTRL1, 8'hFF);
      presetn <= 1'b0;
      @(posedge pclk);
      chk("vector_addr", 0, {20'h00000, vector_addr});
      chk("pullup_en", 0, {30'h00000000, pullup_en});
      presetn <= 1'b1;
      rd(`MIC_OFF_CTRL1, 8'h00, 1'b0);
      conclude;
   end
endmodule
